// ### rtl/hdt_pkg.sv
// constants for the headset detection pulse tuning block
package hdt_pkg;

  // ****************************************************************
  // bus and register map
  // ****************************************************************
  localparam int unsigned ADDR_W        = 12;
  localparam logic [9:0]  TUNE_ONE_IDX  = 10'h077;   // register index, byte address is four times it
  localparam logic [9:0]  TUNE_TWO_IDX  = 10'h078;
  localparam logic [11:0] TUNE_ONE_ADDR = {TUNE_ONE_IDX, 2'b00};
  localparam logic [11:0] TUNE_TWO_ADDR = {TUNE_TWO_IDX, 2'b00};
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0]  TUNE_ONE_RST  = 8'h94;     // period 2, high duration 5, scale x1, auto on
  localparam logic [7:0]  TUNE_TWO_RST  = 8'h42;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned PER_HI    = 7;
  localparam int unsigned PER_LO    = 6;
  localparam int unsigned DUR_HI    = 5;
  localparam int unsigned DUR_LO    = 2;
  localparam int unsigned SCALE_BIT = 1;
  localparam int unsigned AUTO_BIT  = 0;
  localparam int unsigned WID_HI    = 7;
  localparam int unsigned WID_LO    = 4;
  localparam int unsigned RSV_BIT   = 3;
  localparam int unsigned RANGE_BIT = 2;
  localparam int unsigned IN4_HI    = 1;
  localparam int unsigned IN4_LO    = 0;

  // ****************************************************************
  // codes and timing counts, in low-frequency oscillator cycles
  // ****************************************************************
  localparam logic [1:0]  PER_OFF       = 2'h0;
  localparam logic [1:0]  PER_SHORT     = 2'h1;
  localparam logic [1:0]  PER_MID       = 2'h2;
  localparam logic [1:0]  PER_LONG      = 2'h3;
  localparam logic [15:0] PER_SHORT_CYC = 16'h0090;  // 144
  localparam logic [15:0] PER_MID_CYC   = 16'h0120;  // 288
  localparam logic [15:0] PER_LONG_CYC  = 16'h1200;  // 4608
  localparam logic [1:0]  AUTO_PER_CODE = PER_LONG;
  localparam logic        AUTO_SCALE    = 1'b1;
  localparam logic [15:0] SCALE_X1      = 16'h0001;
  localparam logic [15:0] SCALE_X8      = 16'h0008;
  localparam logic [1:0]  IN4_ON        = 2'h1;
  localparam logic [1:0]  IN4_OFF       = 2'h2;

endpackage : hdt_pkg

// ### rtl/hdt_top.sv
// headset detection pulse tuning: register file, auto configuration and pulse generators
//
// How it works
// - auto bit clear: mic insertion forces period 4608 cycles and scale eight
// - auto bit set: mic insertion leaves period and scale as programmed
// - separate headset pulse generated for button press and removal sensing
// - headset pulse width is (code/2+1) times (period/2+1) oscillator cycles
// - range bit selects 16-300 ohm or 16-64 ohm load detection
// - input pair field 01 enables headset mic inputs, 10 disables
// - period code: 0 off, 1 is 144, 2 is 288, 3 is 4608 cycles
// - scale bit 0 gives factor one, scale bit 1 gives factor eight
`timescale 1ns/10ps
module hdt_top (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_b,
  input  wire logic                       i_low_freq_osc_clock,
  input  wire logic                       i_mic_insert,
  input  wire logic [hdt_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  input  wire logic                       i_s_axi_awvalid,
  output logic                            o_s_axi_awready,
  input  wire logic [31:0]                i_s_axi_wdata,
  input  wire logic [3:0]                 i_s_axi_wstrb,
  input  wire logic                       i_s_axi_wvalid,
  output logic                            o_s_axi_wready,
  output logic [1:0]                      o_s_axi_bresp,
  output logic                            o_s_axi_bvalid,
  input  wire logic                       i_s_axi_bready,
  input  wire logic [hdt_pkg::ADDR_W-1:0] i_s_axi_araddr,
  input  wire logic                       i_s_axi_arvalid,
  output logic                            o_s_axi_arready,
  output logic [31:0]                     o_s_axi_rdata,
  output logic [1:0]                      o_s_axi_rresp,
  output logic                            o_s_axi_rvalid,
  input  wire logic                       i_s_axi_rready,
  output logic                            o_load_detect_pulse,
  output logic                            o_headset_detect_pulse,
  output logic                            o_load_range_narrow,
  output logic                            o_fourth_left_analog_input_en,
  output logic                            o_fourth_right_analog_input_en
);
  import hdt_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic              lf_s1;
    logic              lf_s2;
    logic              lf_s3;
    logic              mic_s1;
    logic              mic_s2;
    logic              mic_s3;
    logic [7:0]        tune_one;
    logic [7:0]        tune_two;
    logic              aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic              w_held;
    logic [7:0]        wdata;
    logic              wstrb0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [7:0]        rdata;
    logic [1:0]        rresp;
    logic [15:0]       ld_cnt;
    logic              ld_pulse;
    logic [15:0]       hs_cnt;
    logic              hs_pulse;
  } hdt_state_t;

  hdt_state_t s;
  hdt_state_t next_s;

  // ****************************************************************
  // helpers
  // ****************************************************************

  // period code to cycle count, zero means pulse mode off
  function automatic logic [15:0] hdt_period(input logic [1:0] code);
    logic [15:0] cyc;
    cyc = 16'h0000;
    case (code)
      PER_SHORT: cyc = PER_SHORT_CYC;
      PER_MID:   cyc = PER_MID_CYC;
      PER_LONG:  cyc = PER_LONG_CYC;
      default:   cyc = 16'h0000;
    endcase
    return cyc;
  endfunction : hdt_period

  // headset width = (code+2)*(period/2+1)/2, odd halves round down
  function automatic logic [15:0] hdt_hs_width(input logic [3:0] code, input logic [15:0] per);
    logic [19:0] half;
    logic [19:0] mult;
    logic [19:0] prod;
    half = {5'h00, per[15:1]} + 20'h00001;
    mult = {15'h0000, {1'b0, code} + 5'h02};
    prod = half * mult;
    return prod[16:1];
  endfunction : hdt_hs_width

  // register readback, reserved bits already held at zero
  function automatic logic [8:0] hdt_read(input logic [ADDR_W-1:0] addr, input hdt_state_t st);
    logic [8:0] r;
    r = 9'h100;
    if (addr == TUNE_ONE_ADDR) begin
      r = {1'b0, st.tune_one};
    end else if (addr == TUNE_TWO_ADDR) begin
      r = {1'b0, st.tune_two};
    end
    return r;
  endfunction : hdt_read

  logic        lf_tick;
  logic        mic_event;
  logic [15:0] ld_period;
  logic [15:0] ld_scale;
  logic [15:0] ld_high;
  logic [15:0] hs_width;
  logic [15:0] hs_span;
  logic [15:0] ld_cnt_inc;
  logic [15:0] hs_cnt_inc;
  logic        wr_hit_one;
  logic        wr_hit_two;
  logic [8:0]  rd_word;

  // edges seen only on the second and third sync stages
  assign lf_tick   = s.lf_s2 & ~s.lf_s3;
  assign mic_event = s.mic_s2 & ~s.mic_s3;

  // ****************************************************************
  // pulse shape decode
  // ****************************************************************

  assign ld_period = hdt_period(s.tune_one[PER_HI:PER_LO]);
  assign ld_scale  = s.tune_one[SCALE_BIT] ? SCALE_X8 : SCALE_X1;
  // high duration is duration code times scale; code zero yields no high phase
  assign ld_high   = 16'({12'h000, s.tune_one[DUR_HI:DUR_LO]} * ld_scale);
  assign hs_width  = hdt_hs_width(s.tune_two[WID_HI:WID_LO], ld_period);
  // headset pulse runs at half duty, so its full cycle is twice the width
  assign hs_span   = {hs_width[14:0], 1'b0};
  assign ld_cnt_inc = s.ld_cnt + 16'h0001;
  assign hs_cnt_inc = s.hs_cnt + 16'h0001;

  // write address decode
  assign wr_hit_one = (s.awaddr == TUNE_ONE_ADDR);
  assign wr_hit_two = (s.awaddr == TUNE_TWO_ADDR);
  assign rd_word    = hdt_read(i_s_axi_araddr, s);

  // ****************************************************************
  // next state
  // ****************************************************************

  // one process for all state: sync, bus, registers, auto config, pulses
  always_comb begin
    next_s = s;

    // two-flop synchronisers, third stage only for edge detection
    next_s.lf_s1  = i_low_freq_osc_clock;
    next_s.lf_s2  = s.lf_s1;
    next_s.lf_s3  = s.lf_s2;
    next_s.mic_s1 = i_mic_insert;
    next_s.mic_s2 = s.mic_s1;
    next_s.mic_s3 = s.mic_s2;

    // capture address and data independently, in either order
    if (i_s_axi_awvalid && o_s_axi_awready) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr  = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && o_s_axi_wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata  = i_s_axi_wdata[7:0];
      next_s.wstrb0 = i_s_axi_wstrb[0];
    end

    // commit a write once both halves are here
    if (s.aw_held && s.w_held && !s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = RESP_OKAY;
      if (wr_hit_one) begin
        if (s.wstrb0) begin
          next_s.tune_one = s.wdata;
        end
      end else if (wr_hit_two) begin
        if (s.wstrb0) begin
          next_s.tune_two = s.wdata & ~(8'h01 << RSV_BIT);
        end
      end else begin
        next_s.bresp = RESP_SLVERR;
      end
    end
    if (s.bvalid && i_s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // reads answer one cycle after the address is taken
    if (i_s_axi_arvalid && o_s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd_word[7:0];
      next_s.rresp  = rd_word[8] ? RESP_SLVERR : RESP_OKAY;
    end
    if (s.rvalid && i_s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end

    // auto reconfiguration, applied after a software write so it wins
    if (mic_event && !s.tune_one[AUTO_BIT]) begin
      next_s.tune_one[PER_HI:PER_LO] = AUTO_PER_CODE;
      next_s.tune_one[SCALE_BIT]     = AUTO_SCALE;
    end
    // with the auto bit set the programmed fields are left alone

    // load detection pulse, stepped on each rising oscillator edge
    if (lf_tick) begin
      if (ld_period == 16'h0000) begin
        next_s.ld_cnt   = 16'h0000;
        next_s.ld_pulse = 1'b0;
      end else if (ld_cnt_inc >= ld_period) begin
        next_s.ld_cnt   = 16'h0000;
        next_s.ld_pulse = (ld_high != 16'h0000);
      end else begin
        next_s.ld_cnt   = ld_cnt_inc;
        next_s.ld_pulse = (ld_cnt_inc < ld_high);
      end

      // separate headset pulse, free running with its own counter
      if (hs_cnt_inc >= hs_span) begin
        next_s.hs_cnt   = 16'h0000;
        next_s.hs_pulse = 1'b1;
      end else begin
        next_s.hs_cnt   = hs_cnt_inc;
        next_s.hs_pulse = (hs_cnt_inc < hs_width);
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************

  // reset loads constants only
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s          <= '0;
      s.tune_one <= TUNE_ONE_RST;
      s.tune_two <= TUNE_TWO_RST;
      s.bresp    <= RESP_OKAY;
      s.rresp    <= RESP_OKAY;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************

  // one write and one read in flight at a time keeps the slave simple
  assign o_s_axi_awready = !s.aw_held && !s.bvalid;
  assign o_s_axi_wready  = !s.w_held && !s.bvalid;
  assign o_s_axi_bvalid  = s.bvalid;
  assign o_s_axi_bresp   = s.bresp;
  assign o_s_axi_arready = !s.rvalid;
  assign o_s_axi_rvalid  = s.rvalid;
  assign o_s_axi_rdata   = {24'h000000, s.rdata};
  assign o_s_axi_rresp   = s.rresp;

  assign o_load_detect_pulse    = s.ld_pulse;
  assign o_headset_detect_pulse = s.hs_pulse;
  // range select to the analog comparator
  assign o_load_range_narrow    = s.tune_two[RANGE_BIT];
  // input pair enable; reserved codes count as disabled
  assign o_fourth_left_analog_input_en  = (s.tune_two[IN4_HI:IN4_LO] == IN4_ON);
  assign o_fourth_right_analog_input_en = (s.tune_two[IN4_HI:IN4_LO] == IN4_ON);

endmodule : hdt_top

// ### dv/hdt_monitor.sv
// checker for the headset detection pulse tuning block
`timescale 1ns/10ps
module hdt_monitor (
  input wire logic                       i_clk,
  input wire logic                       i_rst_b,
  input wire logic                       i_s_axi_awvalid,
  input wire logic                       o_s_axi_awready,
  input wire logic                       i_s_axi_wvalid,
  input wire logic                       o_s_axi_wready,
  input wire logic                       o_s_axi_bvalid,
  input wire logic [hdt_pkg::ADDR_W-1:0] i_s_axi_araddr,
  input wire logic                       i_s_axi_arvalid,
  input wire logic                       o_s_axi_arready,
  input wire logic [31:0]                o_s_axi_rdata,
  input wire logic [1:0]                 o_s_axi_rresp,
  input wire logic                       o_s_axi_rvalid,
  input wire logic                       o_load_range_narrow,
  input wire logic                       o_fourth_left_analog_input_en,
  input wire logic                       o_fourth_right_analog_input_en
);
  import hdt_pkg::*;
  // ****************************************************************
  // helpers
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  logic [ADDR_W-1:0] rd_addr;
  // address of the read under way, so read data can be judged per register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_addr <= '0;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      rd_addr <= i_s_axi_araddr;
    end
  end
  sequence s_wr_take;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  endsequence
  sequence s_rd_take;
    i_s_axi_arvalid && o_s_axi_arready;
  endsequence
  // ****************************************************************
  // properties
  // ****************************************************************
  property p_wr_answer; s_wr_take |-> ##2 o_s_axi_bvalid; endproperty
  property p_rd_answer; s_rd_take |=> o_s_axi_rvalid; endproperty
  property p_aw_block; o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready; endproperty
  property p_ar_block; o_s_axi_rvalid |-> !o_s_axi_arready; endproperty
  property p_rsv_zero;
    o_s_axi_rvalid && rd_addr == TUNE_TWO_ADDR |-> o_s_axi_rdata[RSV_BIT] == 1'b0 && o_s_axi_rdata[31:8] == 24'h0;
  endproperty
  property p_unmapped;
    o_s_axi_rvalid && rd_addr != TUNE_ONE_ADDR && rd_addr != TUNE_TWO_ADDR |->
      o_s_axi_rresp == RESP_SLVERR && o_s_axi_rdata == 32'h0;
  endproperty
  property p_pair; o_fourth_left_analog_input_en == o_fourth_right_analog_input_en; endproperty
  // read data is captured from the same register word that drives the pins one cycle earlier
  property p_in4_read;
    $rose(o_s_axi_rvalid) && rd_addr == TUNE_TWO_ADDR |->
      $past(o_fourth_left_analog_input_en) == (o_s_axi_rdata[IN4_HI:IN4_LO] == IN4_ON);
  endproperty
  property p_range_read;
    $rose(o_s_axi_rvalid) && rd_addr == TUNE_TWO_ADDR |->
      $past(o_load_range_narrow) == o_s_axi_rdata[RANGE_BIT];
  endproperty
  // pins only move when software commits a write
  property p_in4_cause; $changed(o_fourth_left_analog_input_en) |-> ##[0:2] o_s_axi_bvalid; endproperty
  property p_range_cause; $changed(o_load_range_narrow) |-> ##[0:2] o_s_axi_bvalid; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response not two cycles after take");
  a_rd_answer: assert property (p_rd_answer) else $error("read data not one cycle after take");
  a_aw_block: assert property (p_aw_block) else $error("write channels ready while response pending");
  a_ar_block: assert property (p_ar_block) else $error("read address ready while data pending");
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bit read back nonzero");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  a_pair: assert property (p_pair) else $error("input pair enables differ");
  a_in4_read: assert property (p_in4_read) else $error("input pair enable disagrees with field");
  a_range_read: assert property (p_range_read) else $error("range output disagrees with field");
  a_in4_cause: assert property (p_in4_cause) else $error("input pair enable moved without write");
  a_range_cause: assert property (p_range_cause) else $error("range moved without write");
endmodule : hdt_monitor

bind hdt_top hdt_monitor u_mon (.i_clk, .i_rst_b, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wvalid,
  .o_s_axi_wready, .o_s_axi_bvalid, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata,
  .o_s_axi_rresp, .o_s_axi_rvalid, .o_load_range_narrow, .o_fourth_left_analog_input_en,
  .o_fourth_right_analog_input_en);

// ### dv/tb_headset_detect_pulse_tuning.sv
// self-checking bench for the headset detection pulse tuning block
`timescale 1ns/10ps
module tb_headset_detect_pulse_tuning;
  import hdt_pkg::*;
  logic        clk, rst_b, lf, mic, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, lpulse, hpulse, narrow, fourth_left_analog_input, fourth_right_analog_input;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  int          miscompares, cmp_count, lf_div;
  logic [7:0]  d8;
  logic [1:0]  r2;
  int          hi, per, w;

  hdt_top DUT (.i_clk(clk), .i_rst_b(rst_b), .i_low_freq_osc_clock(lf), .i_mic_insert(mic),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .o_load_detect_pulse(lpulse), .o_headset_detect_pulse(hpulse),
    .o_load_range_narrow(narrow), .o_fourth_left_analog_input_en(fourth_left_analog_input), .o_fourth_right_analog_input_en(fourth_right_analog_input));

  // ****************************************************************
  // clock and oscillator; oscillator period is 8 clocks, well under half rate
  // ****************************************************************
  always #25 clk = ~clk;
  always @(posedge clk) begin
    lf_div <= lf_div + 1;
    if (lf_div % 4 == 3) lf <= ~lf;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic close_out();
    if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // handshakes are judged at the rising edge itself; releases follow by non-blocking update
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    logic dn;
    dn = 0;
    @(posedge clk);
    awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
    for (n = 0; n < 20 && !dn; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) begin
        dn = 1;
        r = bresp;
        bready <= 0;
      end
    end
    if (!dn) begin miscompares++; close_out(); end
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
    int n;
    logic dn;
    dn = 0;
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    for (n = 0; n < 20 && !dn; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) begin
        dn = 1;
        r = rresp;
        d = rdata[7:0];
        rready <= 0;
      end
    end
    if (!dn) begin miscompares++; close_out(); end
  endtask : axi_rd
  task automatic mic_event();
    @(posedge clk) mic <= 1;
    repeat (4) @(posedge clk);
    mic <= 0;
    repeat (4) @(posedge clk);
  endtask : mic_event
  // high time and period of a pulse, in oscillator ticks, between two rises
  task automatic meas(input logic hs, output int h, output int p);
    int n, ph;
    logic cur, was, lp;
    h = 0; p = 0; ph = 0; was = 1; lp = 1;
    for (n = 0; n < 30000 && ph < 2; n++) begin
      @(posedge clk);
      cur = hs ? hpulse : lpulse;
      if (cur && !was) ph++;
      if (lf && !lp && ph == 1) begin p++; if (cur) h++; end
      was = cur; lp = lf;
    end
    if (ph < 2) begin miscompares++; close_out(); end
  endtask : meas

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    axi_rd(TUNE_ONE_ADDR, d8, r2); chk("one reset", 32'h94, {24'h0, d8});
    chk("rd okay", {30'h0, RESP_OKAY}, {30'h0, r2});
    axi_rd(TUNE_TWO_ADDR, d8, r2); chk("two reset", 32'h42, {24'h0, d8});
    chk("in4 reset", 32'h0, {31'h0, fourth_left_analog_input});
  endtask : t_reset
  task automatic t_unmapped();
    axi_wr(12'h000, 8'hFF, r2); chk("wr unmapped", {30'h0, RESP_SLVERR}, {30'h0, r2});
    axi_rd(12'h004, d8, r2); chk("rd unmapped", {30'h0, RESP_SLVERR}, {30'h0, r2});
  endtask : t_unmapped
  task automatic t_auto();
    axi_wr(TUNE_ONE_ADDR, 8'h94, r2); chk("wr okay", {30'h0, RESP_OKAY}, {30'h0, r2});
    mic_event(); axi_rd(TUNE_ONE_ADDR, d8, r2);
    chk("auto on", 32'hD6, {24'h0, d8});
    axi_wr(TUNE_ONE_ADDR, 8'h55, r2); mic_event(); axi_rd(TUNE_ONE_ADDR, d8, r2);
    chk("auto off", 32'h55, {24'h0, d8});
  endtask : t_auto
  // software side keeps the pair field legal and the reserved bit clear
  task automatic t_two();
    axi_wr(TUNE_TWO_ADDR, 8'h05, r2); axi_rd(TUNE_TWO_ADDR, d8, r2);
    chk("two rsv", 32'h05, {24'h0, d8});
    chk("narrow", 32'h1, {31'h0, narrow});
    chk("in4 on", 32'h1, {31'h0, fourth_right_analog_input});
    axi_wr(TUNE_TWO_ADDR, 8'h02, r2); axi_rd(TUNE_TWO_ADDR, d8, r2);
    chk("two back", 32'h02, {24'h0, d8});
    chk("wide", 32'h0, {31'h0, narrow});
    chk("in4 off", 32'h0, {31'h0, fourth_left_analog_input});
  endtask : t_two
  task automatic t_pulse();
    int c, n;
    axi_wr(TUNE_ONE_ADDR, 8'h45, r2); meas(0, hi, per);
    chk("load hi x1", 32'd1, hi);
    chk("load per 144", 32'd144, per);
    axi_wr(TUNE_ONE_ADDR, 8'h87, r2); meas(0, hi, per);
    chk("load hi x8", 32'd8, hi);
    chk("load per 288", 32'd288, per);
    axi_wr(TUNE_ONE_ADDR, 8'h05, r2);
    repeat (20) @(posedge clk);
    hi = 0;
    for (n = 0; n < 400; n++) begin @(posedge clk); if (lpulse !== 1'b0) hi++; end
    chk("load off", 32'd0, hi);
    axi_wr(TUNE_ONE_ADDR, 8'h45, r2);
    for (c = 0; c < 16; c += 15) begin
      axi_wr(TUNE_TWO_ADDR, {c[3:0], 4'h2}, r2); meas(1, hi, per);
      w = ((c + 2) * (144 / 2 + 1)) / 2;
      chk("hs width", w, hi);
      chk("hs period", 2 * w, per);
    end
  endtask : t_pulse

  initial begin
    clk = 0; rst_b = 0; lf = 0; mic = 0; lf_div = 0; miscompares = 0; cmp_count = 0;
    awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0; awaddr = 0; araddr = 0; wdata = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1;
    t_reset();
    t_unmapped();
    t_auto();
    t_two();
    t_pulse();
    close_out();
  end
endmodule : tb_headset_detect_pulse_tuning
